// [hw/hvss_sequencer.v]
// Shutdown and reset sequencer of a programmable supply supervisor
//
// Summary of operation
// - Channel one over- and under-voltage flags each trigger a shutdown.
// - Over- and under-voltage trip levels each selectable by 4-bit code.
// - The triggering cause is latched into a readable fault record.
// - Warning goes low first, before shutdown asserts.
// - Shutdown waits for the programmed delay, eight choices.
// - Shutdown stays asserted for the programmed hold time, less at most one tick.
// - Hold defaults to 200 ms, delay to 1200 ms.
// - Threshold codes default to 18.00 V over and 8.43 V under.
// - Reset output follows shutdown on high-voltage channel events.
// - Both flags with the hold and delay timers decide both outputs.
// - High-voltage channels drive shutdown; low-voltage channels drive reset.
// - Watchdog and manual-reset requests also assert reset.
// - Manual reset overrides every other reset source.
// - Fourth channel code 0000 removes it from the reset decision.
// - Timing codes are three bits; 000 default, 111 shortest.
//
// Local design decisions: the address-and-strobe port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "hvss_defines.vh"

module hvss_sequencer #(
  parameter TICK_CYCLES = `HVSS_CLK_MHZ * `HVSS_TICK_US
) (
  input  wire        sys_clk,
  input  wire        rst_n,
  input  wire [7:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  input  wire        over_voltage_flag,
  input  wire        under_voltage_flag,
  input  wire        hv_monitor_two,
  input  wire        lv_monitor_three,
  input  wire        lv_monitor_four,
  input  wire        watchdog_input,
  input  wire        manual_reset_req_n,
  output wire [3:0]  ov_code,
  output wire [3:0]  uv_code,
  output wire [3:0]  lv4_code,
  output reg         shutdown_out_n,
  output reg         shutdown_warning_n,
  output reg         reset_out_n,
  output wire        irq
);

  // ==========================================================
  // Reset release and input synchronisers
  // Asynchronous assert; release two edges after the pin rises
  reg rst_meta;
  reg rst_sync;

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // Manual reset inverted first so every synced bit is high-active
  wire [6:0] pins_sync;

  hvss_sync #(
    .WIDTH    (7)
  ) u_sync (
    .clk      (sys_clk),
    .rst_n    (rst_sync),
    .async_in ({over_voltage_flag, under_voltage_flag, hv_monitor_two,
                lv_monitor_three, lv_monitor_four, watchdog_input,
                ~manual_reset_req_n}),
    .sync_out (pins_sync)
  );

  wire ov_s  = pins_sync[6];
  wire uv_s  = pins_sync[5];
  wire hv2_s = pins_sync[4];
  wire lv3_s = pins_sync[3];
  wire lv4_s = pins_sync[2];
  wire wd_s  = pins_sync[1];
  wire mr_s  = pins_sync[0];

  // ==========================================================
  // Timing code decode, shared by hold and delay
  // Code 000 is the slow default, 111 the shortest
  function [20:0] hvss_time_us;
    input       is_delay;
    input [2:0] code;
    begin
      case (code)
        3'h0: hvss_time_us = is_delay ? `HVSS_DELAY_US_0 : `HVSS_HOLD_US_0;
        3'h1: hvss_time_us = is_delay ? `HVSS_DELAY_US_1 : `HVSS_HOLD_US_1;
        3'h2: hvss_time_us = is_delay ? `HVSS_DELAY_US_2 : `HVSS_HOLD_US_2;
        3'h3: hvss_time_us = is_delay ? `HVSS_DELAY_US_3 : `HVSS_HOLD_US_3;
        3'h4: hvss_time_us = is_delay ? `HVSS_DELAY_US_4 : `HVSS_HOLD_US_4;
        3'h5: hvss_time_us = is_delay ? `HVSS_DELAY_US_5 : `HVSS_HOLD_US_5;
        3'h6: hvss_time_us = is_delay ? `HVSS_DELAY_US_6 : `HVSS_HOLD_US_6;
        default: hvss_time_us = is_delay ? `HVSS_DELAY_US_7
                                         : `HVSS_HOLD_US_7;
      endcase
    end
  endfunction

  // ==========================================================
  // Configuration registers
  // Codes hold until rewritten; reset restores the defaults
  reg [3:0] ov_code_r;
  reg [3:0] uv_code_r;
  reg [3:0] lv4_code_r;
  reg [2:0] hold_code;
  reg [2:0] delay_code;

  // Address match, shared by every write decode
  function hvss_hit;
    input [7:0] addr;
    input [7:0] offset;
    begin
      hvss_hit = (addr == offset);
    end
  endfunction

  wire wr_thresh = reg_wr && hvss_hit(reg_addr, `HVSS_ADDR_THRESH);
  wire wr_timing = reg_wr && hvss_hit(reg_addr, `HVSS_ADDR_TIMING);
  wire wr_fault  = reg_wr && hvss_hit(reg_addr, `HVSS_ADDR_FAULT);
  wire wr_irqclr = reg_wr && hvss_hit(reg_addr, `HVSS_ADDR_IRQ_CLR);
  wire wr_irqen  = reg_wr && hvss_hit(reg_addr, `HVSS_ADDR_IRQ_EN);

  always @(posedge sys_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      ov_code_r  <= `HVSS_OV_CODE_RST;
      uv_code_r  <= `HVSS_UV_CODE_RST;
      lv4_code_r <= `HVSS_LV4_CODE_RST;
      hold_code  <= `HVSS_HOLD_RST;
      delay_code <= `HVSS_DELAY_RST;
    end else begin
      if (wr_thresh) begin
        ov_code_r  <= reg_wdata[`HVSS_OV_CODE_LSB +: 4];
        uv_code_r  <= reg_wdata[`HVSS_UV_CODE_LSB +: 4];
        lv4_code_r <= reg_wdata[`HVSS_LV4_CODE_LSB +: 4];
      end
      if (wr_timing) begin
        hold_code  <= reg_wdata[`HVSS_HOLD_LSB +: 3];
        delay_code <= reg_wdata[`HVSS_DELAY_LSB +: 3];
      end
    end
  end

  // Codes go straight to the comparators; ordering is software's job
  assign ov_code  = ov_code_r;
  assign uv_code  = uv_code_r;
  assign lv4_code = lv4_code_r;

  // ==========================================================
  // Microsecond tick and the shared sequencing timer
  // Free-running tick; expiry may land up to one tick early
  // One timer serves delay, then hold; the two never overlap
  reg [15:0] tick_cnt;
  wire       tick = (tick_cnt == 16'h0000);

  always @(posedge sys_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      tick_cnt <= 16'h0000;
    end else if (tick) begin
      tick_cnt <= TICK_CYCLES[15:0] - 16'h0001;
    end else begin
      tick_cnt <= tick_cnt - 16'h0001;
    end
  end

  reg         timer_start;
  reg  [20:0] timer_load;
  wire        timer_run;

  // A start reloads even while running, so no stale count survives
  hvss_timer u_timer (
    .clk     (sys_clk),
    .rst_n   (rst_sync),
    .tick    (tick),
    .start   (timer_start),
    .load    (timer_load),
    .running (timer_run)
  );

  // ==========================================================
  // Shutdown state machine
  // Idle, warning while the delay runs, shutdown while hold runs
  localparam ST_IDLE = 2'b00;
  localparam ST_WARN = 2'b01;
  localparam ST_SHUTDOWN_OUT_N = 2'b10;

  reg  [1:0] state;
  reg  [1:0] next_state;
  wire       trigger = ov_s | uv_s | hv2_s;

  always @* begin
    next_state  = state;
    timer_start = 1'b0;
    timer_load  = hvss_time_us(1'b1, delay_code);
    case (state)
      ST_IDLE: begin
        // Fault record captures the cause on this same edge
        if (trigger) begin
          timer_start = 1'b1;
          next_state  = ST_WARN;
        end
      end
      ST_WARN: begin
        // Flags dropping now do not cancel; shutdown always follows
        if (!timer_run) begin
          timer_start = 1'b1;
          timer_load  = hvss_time_us(1'b0, hold_code);
          next_state  = ST_SHUTDOWN_OUT_N;
        end
      end
      ST_SHUTDOWN_OUT_N: begin
        // Flags still high keep shutdown asserted past the hold
        if (!timer_run && !ov_s && !uv_s && !hv2_s) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  wire shutdown_out_n_next = (next_state == ST_SHUTDOWN_OUT_N);
  wire warn_next = (next_state == ST_WARN) || shutdown_out_n_next;
  wire lv4_used      = (lv4_code_r != `HVSS_LV4_DISABLED);

  // ==========================================================
  // Reset request merge; manual reset cannot be masked
  wire rst_from_mr   = mr_s;
  wire rst_from_shutdown_out_n = shutdown_out_n_next;
  wire rst_from_lv   = lv3_s || (lv4_s && lv4_used);
  wire rst_from_wd   = wd_s;
  wire rst_req       = rst_from_mr || rst_from_shutdown_out_n || rst_from_lv ||
                       rst_from_wd;

  // Registered outputs, so the pins never glitch
  always @(posedge sys_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      state              <= ST_IDLE;
      shutdown_out_n     <= 1'b1;
      shutdown_warning_n <= 1'b1;
      reset_out_n        <= 1'b0;
    end else begin
      state              <= next_state;
      shutdown_out_n     <= !shutdown_out_n_next;
      shutdown_warning_n <= !warn_next;
      reset_out_n        <= !rst_req;
    end
  end

  // ==========================================================
  // Fault record: set wins over a same-cycle clear
  // Causes are captured on the idle-to-warning step only
  reg  [2:0] fault;
  wire       fault_cap = (state == ST_IDLE) && trigger;
  wire [2:0] fault_set = fault_cap ? {hv2_s, uv_s, ov_s} : 3'h0;

  always @(posedge sys_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      fault <= 3'h0;
    end else begin
      fault <= (fault & ~(wr_fault ? reg_wdata[2:0] : 3'h0))
               | fault_set;
    end
  end

  // ==========================================================
  // Interrupt status, enable and clear
  // Clear and enable share the status layout
  reg  [3:0] irq_stat;
  reg  [3:0] irq_en;
  wire [3:0] irq_evt;

  // Shutdown and reset events compare the registered pin with its next value
  wire evt_trigger  = fault_cap;
  wire evt_shutdown_out_n_on  = shutdown_out_n && shutdown_out_n_next;
  wire evt_shutdown_out_n_off = !shutdown_out_n && !shutdown_out_n_next;
  wire evt_rst_on   = reset_out_n && rst_req;

  assign irq_evt = {evt_rst_on, evt_shutdown_out_n_off, evt_shutdown_out_n_on, evt_trigger};

  always @(posedge sys_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      irq_stat <= 4'h0;
      irq_en   <= 4'h0;
    end else begin
      irq_stat <= (irq_stat & ~(wr_irqclr ? reg_wdata[3:0] : 4'h0))
                  | irq_evt;
      if (wr_irqen) begin
        irq_en <= reg_wdata[3:0];
      end
    end
  end

  assign irq = |(irq_stat & irq_en);

  // ==========================================================
  // Read port, data valid the cycle after the strobe
  // Bus reads zero except in the cycle after a read strobe
  reg  [31:0] rd_mux;
  wire [11:0] status_word;

  assign status_word = {state, reset_out_n, shutdown_warning_n,
                        shutdown_out_n, pins_sync};

  always @* begin
    case (reg_addr)
      `HVSS_ADDR_THRESH:   rd_mux = {20'h00000, lv4_code_r, uv_code_r,
                                     ov_code_r};
      `HVSS_ADDR_TIMING:   rd_mux = {25'h0000000, delay_code, 1'b0,
                                     hold_code};
      `HVSS_ADDR_FAULT:    rd_mux = {29'h00000000, fault};
      `HVSS_ADDR_STATE:    rd_mux = {20'h00000, status_word};
      `HVSS_ADDR_IRQ_STAT: rd_mux = {28'h0000000, irq_stat};
      `HVSS_ADDR_IRQ_EN:   rd_mux = {28'h0000000, irq_en};
      default:             rd_mux = 32'h00000000;
    endcase
  end

  always @(posedge sys_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

endmodule

`default_nettype wire

// [hw/hvss_defines.vh]
// Constants of the supervisor shutdown sequencer: offsets, fields, timings
`ifndef HVSS_DEFINES_VH
`define HVSS_DEFINES_VH

// ==========================================================
// Register byte offsets
`define HVSS_ADDR_THRESH   8'h00
`define HVSS_ADDR_TIMING   8'h04
`define HVSS_ADDR_FAULT    8'h08
`define HVSS_ADDR_STATE    8'h0c
`define HVSS_ADDR_IRQ_STAT 8'h10
`define HVSS_ADDR_IRQ_CLR  8'h14
`define HVSS_ADDR_IRQ_EN   8'h18

// ==========================================================
// Field positions
`define HVSS_OV_CODE_LSB   0
`define HVSS_UV_CODE_LSB   4
`define HVSS_LV4_CODE_LSB  8
`define HVSS_HOLD_LSB      0
`define HVSS_DELAY_LSB     4

// ==========================================================
// Reset values: 18.00 V OV, 8.43 V UV, fourth channel off
`define HVSS_OV_CODE_RST   4'h0
`define HVSS_UV_CODE_RST   4'h0
`define HVSS_LV4_CODE_RST  4'h0
`define HVSS_LV4_DISABLED  4'h0
`define HVSS_HOLD_RST      3'h0
`define HVSS_DELAY_RST     3'h0

// ==========================================================
// Timing: clock rate and per-code times in microseconds
`define HVSS_CLK_MHZ       100
`define HVSS_TICK_US       1
`define HVSS_HOLD_US_0     21'd200000
`define HVSS_HOLD_US_1     21'd150000
`define HVSS_HOLD_US_2     21'd100000
`define HVSS_HOLD_US_3     21'd80000
`define HVSS_HOLD_US_4     21'd60000
`define HVSS_HOLD_US_5     21'd40000
`define HVSS_HOLD_US_6     21'd20000
`define HVSS_HOLD_US_7     21'd70
`define HVSS_DELAY_US_0    21'd1200000
`define HVSS_DELAY_US_1    21'd1000000
`define HVSS_DELAY_US_2    21'd800000
`define HVSS_DELAY_US_3    21'd400000
`define HVSS_DELAY_US_4    21'd200000
`define HVSS_DELAY_US_5    21'd100000
`define HVSS_DELAY_US_6    21'd50000
`define HVSS_DELAY_US_7    21'd70

`endif

// [hw/hvss_sync.v]
// Two-stage synchroniser for a vector of asynchronous levels
`timescale 1ns/10ps
`default_nettype none

module hvss_sync #(
  parameter WIDTH = 1
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      reg meta;
      reg stable;
      // First stage feeds only the second stage
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          meta   <= 1'b0;
          stable <= 1'b0;
        end else begin
          meta   <= async_in[i];
          stable <= meta;
        end
      end
      assign sync_out[i] = stable;
    end
  endgenerate

endmodule

`default_nettype wire

// [hw/hvss_timer.v]
// Loadable down-counter stepped by a microsecond tick
`timescale 1ns/10ps
`default_nettype none

module hvss_timer (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        tick,
  input  wire        start,
  input  wire [20:0] load,
  output reg         running
);

  reg [20:0] count;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count   <= 21'h000000;
      running <= 1'b0;
    end else if (start) begin
      count   <= load;
      running <= 1'b1;
    end else if (running && tick) begin
      if (count <= 21'h000001) begin
        running <= 1'b0;
      end
      count <= count - 21'h000001;
    end
  end

endmodule

`default_nettype wire

// [test/hvss_seq_monitor.sv]
// Checker of the shutdown, warning and reset pin sequencing
`timescale 1ns/10ps
`default_nettype none

module hvss_seq_monitor #(
  parameter TICK_CYCLES = 100
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic over_voltage_flag,
  input wire logic under_voltage_flag,
  input wire logic hv_monitor_two,
  input wire logic watchdog_input,
  input wire logic manual_reset_req_n,
  input wire logic shutdown_out_n,
  input wire logic shutdown_warning_n,
  input wire logic reset_out_n
);
  // ==========================================================
  // Low-time counters; 69 ticks leaves room for tick jitter
  localparam int MIN_CNT = 69 * TICK_CYCLES;
  logic [23:0] warn_cnt;
  logic [23:0] shutdown_out_n_cnt;
  logic        any_hv;
  assign any_hv = over_voltage_flag | under_voltage_flag | hv_monitor_two;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      warn_cnt <= 24'h0;
      shutdown_out_n_cnt <= 24'h0;
    end else begin
      warn_cnt <= shutdown_warning_n ? 24'h0 : warn_cnt + {23'h0, ~&warn_cnt};
      shutdown_out_n_cnt <= shutdown_out_n ? 24'h0 : shutdown_out_n_cnt + {23'h0, ~&shutdown_out_n_cnt};
    end
  end

  // ==========================================================
  // Properties
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  hv_trigger_a: assert property (any_hv [*6] |-> !shutdown_warning_n)
    else $error("flag held without warning");
  warn_first_a: assert property (
    $fell(shutdown_out_n) |-> !$past(shutdown_warning_n))
    else $error("shutdown without prior warning");
  delay_min_a: assert property (
    $fell(shutdown_out_n) |-> warn_cnt >= MIN_CNT)
    else $error("shutdown before delay");
  hold_min_a: assert property (
    $rose(shutdown_out_n) |-> shutdown_out_n_cnt >= MIN_CNT)
    else $error("shutdown released before hold");
  reset_track_a: assert property (
    !shutdown_out_n && !$past(shutdown_out_n) |-> !reset_out_n)
    else $error("reset not following shutdown");
  wdog_reset_a: assert property (watchdog_input [*4] |-> !reset_out_n)
    else $error("watchdog did not reset");
  mr_priority_a: assert property (
    !manual_reset_req_n [*4] |-> !reset_out_n)
    else $error("manual reset ignored");
  clear_release_a: assert property (
    $rose(shutdown_warning_n) |-> !$past(any_hv, 3) && shutdown_out_n)
    else $error("release while flags active");

  cover property ($fell(shutdown_out_n));
  cover property ($rose(shutdown_out_n));
  cover property ($fell(manual_reset_req_n));
endmodule

bind hvss_sequencer hvss_seq_monitor #(.TICK_CYCLES(TICK_CYCLES)) i_mon (
  .sys_clk(sys_clk), .rst_n(rst_n), .over_voltage_flag(over_voltage_flag),
  .under_voltage_flag(under_voltage_flag), .hv_monitor_two(hv_monitor_two),
  .watchdog_input(watchdog_input), .manual_reset_req_n(manual_reset_req_n),
  .shutdown_out_n(shutdown_out_n), .shutdown_warning_n(shutdown_warning_n),
  .reset_out_n(reset_out_n));
`default_nettype wire

// [test/hvss_supply_model.sv]
// Supplies and processor side: comparator flags and reset requests
`timescale 1ns/10ps
`default_nettype none

module hvss_supply_model (
  input  wire logic [6:0] cmd,
  output wire logic [6:0] flags,
  output wire logic       manual_reset_req_n
);
  // Comparators switch off the clock grid, as analog parts do
  assign #3 flags = {1'b0, cmd[5:0]};
  // Pulled up when nobody presses the button
  assign #4 manual_reset_req_n = ~cmd[6];
endmodule
`default_nettype wire

// [test/hvss_sequencer_tb.sv]
// Self-checking bench of the shutdown sequencer
`timescale 1ns/10ps
`default_nettype none

module hvss_sequencer_tb;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        rd_d = 1'b0;
  logic [6:0]  cmd = 7'h00;
  wire  [6:0]  fl;
  wire  [31:0] rdat;
  wire  [3:0]  ovc;
  wire  [3:0]  uvc;
  wire  [3:0]  l4c;
  wire         mr_n;
  wire         shutdown_out_n_n;
  wire         warn_n;
  wire         rst_o_n;
  wire         irq;
  logic [31:0] exp_q[$];
  logic [31:0] v;
  int          error_cnt = 0;
  int          checks_done = 0;
  int          n;

  always #5 sys_clk = ~sys_clk;

  hvss_supply_model i_hvss_supply_model (.cmd(cmd), .flags(fl),
    .manual_reset_req_n(mr_n));
  hvss_sequencer #(.TICK_CYCLES(1)) i_hvss_sequencer (.sys_clk(sys_clk),
    .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdat),
    .over_voltage_flag(fl[0]), .under_voltage_flag(fl[1]),
    .hv_monitor_two(fl[2]), .lv_monitor_three(fl[3]),
    .lv_monitor_four(fl[4]), .watchdog_input(fl[5]),
    .manual_reset_req_n(mr_n), .ov_code(ovc), .uv_code(uvc),
    .lv4_code(l4c), .shutdown_out_n(shutdown_out_n_n),
    .shutdown_warning_n(warn_n), .reset_out_n(rst_o_n), .irq(irq));

  task automatic tally_and_finish;
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // Expected value is queued; the watcher below pops it
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    exp_q.push_back(e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
  endtask

  // Waits for {shutdown, warning, reset}; n counts the cycles
  task automatic wait_pins(input logic [2:0] want);
    n = 0;
    while ({shutdown_out_n_n, warn_n, rst_o_n} !== want) begin
      @(posedge sys_clk);
      n++;
      if (n > 400) begin
        $display("mismatch at %0t: pin wait timed out", $time);
        error_cnt++;
        tally_and_finish();
      end
    end
  endtask

  always @(posedge sys_clk) begin
    rd_d <= reg_rd;
    if (rd_d) begin
      chk(rdat, exp_q.pop_front());
    end
  end

  initial begin
    void'($urandom(95));
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h0);
    rd(8'h1c, 32'h0);
    rd(8'h0c, 32'h380);
    // OV code 1 (18.86) stays above UV code 0 (8.43)
    v = ($urandom_range(1, 15) << 8) | 32'h01;
    wr(8'h00, v);
    rd(8'h00, v);
    chk({20'h0, l4c, uvc, ovc}, v);
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h77);
    rd(8'h04, 32'h77);
    for (int i = 0; i < 3; i++) begin
      wr(8'h18, (i == 2) ? 32'h0 : 32'h1);
      cmd <= 7'h01 << i;
      wait_pins(3'b101);
      wait_pins(3'b000);
      chk(n >= 68, 1);
      chk(irq, (i == 2) ? 1'b0 : 1'b1);
      rd(8'h0c, 32'h800 | (32'h40 >> i));
      repeat ((i == 0) ? 20 : 100) @(posedge sys_clk);
      chk({shutdown_out_n_n, warn_n, rst_o_n}, 3'b000);
      cmd <= 7'h00;
      wait_pins(3'b111);
      chk((i == 0) ? (n >= 45) : (n <= 10), 1);
      rd(8'h08, 32'h1 << i);
      rd(8'h10, 32'hf);
      wr(8'h08, 32'h7);
      wr(8'h14, 32'hf);
      rd(8'h08, 32'h0);
      chk(irq, 1'b0);
    end
    wr(8'h00, 32'h100);
    for (int i = 3; i < 8; i++) begin
      if (i == 7) begin
        wr(8'h00, 32'h0);
      end
      cmd <= 7'h01 << ((i == 7) ? 4 : i);
      repeat (6) @(posedge sys_clk);
      chk(rst_o_n, (i == 7) ? 1'b1 : 1'b0);
      chk(shutdown_out_n_n, 1'b1);
      cmd <= 7'h00;
      wait_pins(3'b111);
    end
    repeat (3) @(posedge sys_clk);
    tally_and_finish();
  end
endmodule
`default_nettype wire
